//--- src/lsbs_params.svh
// Constants of the low-side brake sequencer: register offsets, fields, resets, timing.
// Assumes inclusion by the top module and the checker only.
`ifndef LSBS_PARAMS_SVH
`define LSBS_PARAMS_SVH
`define LSBS_OFF_CTRL       12'h000
`define LSBS_OFF_PULSE      12'h004
`define LSBS_OFF_GROUP      12'h008
`define LSBS_OFF_ONTIME     12'h00c
`define LSBS_OFF_OFFTIME    12'h010
`define LSBS_OFF_GUARD      12'h014
`define LSBS_OFF_COAST      12'h018
`define LSBS_OFF_STATUS     12'h01c
`define LSBS_CTRL_BRAKE_EN  0
`define LSBS_CTRL_FORCE     1
`define LSBS_RST_CTRL       32'h0000_0001
`define LSBS_RST_PULSE      8'h04
`define LSBS_RST_GROUP      8'h02
`define LSBS_RST_ONTIME     16'h0019
`define LSBS_RST_OFFTIME    16'h0019
`define LSBS_RST_GUARD      16'h0100
`define LSBS_RST_COAST      16'h0010
`define LSBS_TICK_US        1
`define LSBS_CLK_MHZ        25
`define LSBS_TICK_CYC       (`LSBS_TICK_US * `LSBS_CLK_MHZ)
`endif

//--- src/lsbs_pkg.sv
// Types of the low-side brake sequencer.
// Assumes nothing beyond the params header.
package lsbs_pkg;
  typedef enum logic [2:0] {
    LSBS_IDLE  = 3'b000,
    LSBS_CHECK = 3'b001,
    LSBS_COAST = 3'b010,
    LSBS_ON    = 3'b011,
    LSBS_OFF   = 3'b100,
    LSBS_DONE  = 3'b101
  } lsbs_state_type;
endpackage

//--- src/lsbs_top.sv
// Low-side brake sequencer with APB register file.
// Assumes synchronous inputs at CLK_SYS_I and an APB master on the same clock.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "lsbs_params.svh"

// Functional notes
// - With brake-on-stop enabled, an off command brakes the low sides instead of releasing the bridge.
// - Each brake pulse closes all low sides for the on-time, then opens them for the off-time.
// - The pulse repeats the pulse-count times to form one group.
// - The group repeats the group-repeat-count times.
// - Off-time zero with on-time at maximum keeps the low sides on for the whole braking period.
// - At or above the overspeed threshold at a brake command, the motor coasts for the coast interval.
// - After the coast interval the speed is sampled again before braking.
// - Braking starts only when the frequency is below the overspeed threshold.
// - While forced brake is selected, the brake state is kept and not left.
// - Supply pump-up limits are disabled while low-side braking runs.
module lsbs_top #(
  parameter int PULSE_W = 8,
  parameter int TIME_W  = 16
) (
  input  wire logic                  CLK_SYS_I,       // 25 MHz clock
  input  wire logic                  RST_I,           // Sync reset, high
  input  wire logic                  PSEL_I,          // APB select
  input  wire logic                  PENABLE_I,       // APB enable
  input  wire logic                  PWRITE_I,        // APB direction
  input  wire logic [11:0]           PADDR_I,         // APB byte address
  input  wire logic [31:0]           PWDATA_I,        // APB write data
  output logic      [31:0]           PRDATA_O,        // APB read data
  output logic                       PREADY_O,        // APB ready
  output logic                       PSLVERR_O,       // APB error
  input  wire logic                  OFF_CMD_I,       // Stop or brake command level
  input  wire logic [15:0]           EFREQ_I,         // Estimated electrical frequency
  output logic                       LOWSIDE_ON_O,    // All low-side switches closed
  output logic                       BRIDGE_REL_O,    // Bridge released (coast)
  output logic                       BRAKING_O,       // Brake sequence active
  output logic                       PUMPUP_LIM_EN_O  // Supply pump-up limits allowed
);
  import lsbs_pkg::*;

  // Durations run through a 16-bit timer, so wider times cannot be served
  if (PULSE_W < 1 || PULSE_W > 32 || TIME_W < 2 || TIME_W > 16) begin
    $error("lsbs_top: unsupported width");
  end

  logic [31:0]        ctrl_q;
  logic [PULSE_W-1:0] pulse_count_per_group_q;
  logic [PULSE_W-1:0] group_repeat_count_q;
  logic [TIME_W-1:0]  lowside_on_time_q;
  logic [TIME_W-1:0]  lowside_off_time_q;
  logic [15:0]        overspeed_guard_threshold_q;
  logic [15:0]        overspeed_coast_interval_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;

  lsbs_state_type     state_q;
  lsbs_state_type     state_d;
  logic [15:0]        tmr_q;
  logic [15:0]        tmr_d;
  logic [PULSE_W-1:0] pcnt_q;
  logic [PULSE_W-1:0] pcnt_d;
  logic [PULSE_W-1:0] gcnt_q;
  logic [PULSE_W-1:0] gcnt_d;
  logic [4:0]         div_q;
  logic               off_cmd_q;

  // APB decode
  // Read data and error latch at setup so they stand at the access edge
  wire        setup    = PSEL_I && !PENABLE_I;
  wire        wr_en    = PSEL_I && PENABLE_I && PWRITE_I;
  wire        rd_en    = setup && !PWRITE_I;
  wire        brake_en = ctrl_q[`LSBS_CTRL_BRAKE_EN];
  wire        force_br = ctrl_q[`LSBS_CTRL_FORCE];
  wire        addr_ok  = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `LSBS_OFF_STATUS);
  wire        tick     = (div_q == 5'(`LSBS_TICK_CYC - 1));
  wire        too_fast = (EFREQ_I >= overspeed_guard_threshold_q);
  wire        cont_br  = (lowside_off_time_q == '0) && (&lowside_on_time_q);
  wire        cmd_rise = OFF_CMD_I && !off_cmd_q;
  wire        brk_live = (state_q == LSBS_ON) || (state_q == LSBS_OFF) || (state_q == LSBS_DONE);
  wire [31:0] status_w = {21'h0, cont_br, too_fast, OFF_CMD_I, brk_live, 4'h0, state_q};

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      `LSBS_OFF_CTRL:    rd_mux = ctrl_q;
      `LSBS_OFF_PULSE:   rd_mux = 32'(pulse_count_per_group_q);
      `LSBS_OFF_GROUP:   rd_mux = 32'(group_repeat_count_q);
      `LSBS_OFF_ONTIME:  rd_mux = 32'(lowside_on_time_q);
      `LSBS_OFF_OFFTIME: rd_mux = 32'(lowside_off_time_q);
      `LSBS_OFF_GUARD:   rd_mux = {16'h0, overspeed_guard_threshold_q};
      `LSBS_OFF_COAST:   rd_mux = {16'h0, overspeed_coast_interval_q};
      `LSBS_OFF_STATUS:  rd_mux = status_w;
      default:           rd_mux = 32'h0;
    endcase
  endfunction

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = pslverr_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ctrl_q                      <= `LSBS_RST_CTRL;
      pulse_count_per_group_q     <= PULSE_W'(`LSBS_RST_PULSE);
      group_repeat_count_q        <= PULSE_W'(`LSBS_RST_GROUP);
      lowside_on_time_q           <= TIME_W'(`LSBS_RST_ONTIME);
      lowside_off_time_q          <= TIME_W'(`LSBS_RST_OFFTIME);
      overspeed_guard_threshold_q <= `LSBS_RST_GUARD;
      overspeed_coast_interval_q  <= `LSBS_RST_COAST;
      prdata_q                    <= 32'h0;
      pslverr_q                   <= 1'b0;
    end else begin
      pslverr_q <= setup && !addr_ok;
      if (rd_en) begin
        prdata_q <= addr_ok ? rd_mux(PADDR_I) : 32'h0;
      end
      if (wr_en && addr_ok) begin
        case (PADDR_I)
          `LSBS_OFF_CTRL:    ctrl_q <= {30'h0, PWDATA_I[1:0]};
          `LSBS_OFF_PULSE:   pulse_count_per_group_q <= PWDATA_I[PULSE_W-1:0];
          `LSBS_OFF_GROUP:   group_repeat_count_q <= PWDATA_I[PULSE_W-1:0];
          `LSBS_OFF_ONTIME:  lowside_on_time_q <= PWDATA_I[TIME_W-1:0];
          `LSBS_OFF_OFFTIME: lowside_off_time_q <= PWDATA_I[TIME_W-1:0];
          `LSBS_OFF_GUARD:   overspeed_guard_threshold_q <= PWDATA_I[15:0];
          `LSBS_OFF_COAST:   overspeed_coast_interval_q <= PWDATA_I[15:0];
          default:           ;
        endcase
      end
    end
  end

  // 1 us time base shared by all durations
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      div_q     <= 5'h0;
      off_cmd_q <= 1'b0;
      state_q   <= LSBS_IDLE;
      tmr_q     <= 16'h0;
      pcnt_q    <= '0;
      gcnt_q    <= '0;
    end else begin
      div_q     <= tick ? 5'h0 : div_q + 5'h1;
      off_cmd_q <= OFF_CMD_I;
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      pcnt_q    <= pcnt_d;
      gcnt_q    <= gcnt_d;
    end
  end

  // Timer counts ticks remaining; zero lengths pass in one tick.
  wire tmr_done = tick && (tmr_q <= 16'h1);
  wire tmr_dec  = tick && (tmr_q > 16'h1);

  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_dec ? tmr_q - 16'h1 : tmr_q;
    pcnt_d  = pcnt_q;
    gcnt_d  = gcnt_q;
    case (state_q)
      LSBS_IDLE: begin
        if ((cmd_rise && brake_en) || force_br) begin
          state_d = LSBS_CHECK;
        end
      end
      LSBS_CHECK: begin
        if (too_fast) begin
          state_d = LSBS_COAST;
          tmr_d   = overspeed_coast_interval_q;
        end else begin
          state_d = LSBS_ON;
          tmr_d   = 16'(lowside_on_time_q);
          pcnt_d  = pulse_count_per_group_q;
          gcnt_d  = group_repeat_count_q;
        end
      end
      LSBS_COAST: begin
        if (tmr_done) begin
          state_d = LSBS_CHECK;
        end
      end
      LSBS_ON: begin
        if (cont_br) begin
          state_d = LSBS_ON;
        end else if (tmr_done) begin
          state_d = LSBS_OFF;
          tmr_d   = 16'(lowside_off_time_q);
        end
      end
      LSBS_OFF: begin
        if (tmr_done) begin
          tmr_d   = 16'(lowside_on_time_q);
          state_d = LSBS_ON;
          if (pcnt_q > PULSE_W'(1)) begin
            pcnt_d = pcnt_q - PULSE_W'(1);
          end else if (gcnt_q > PULSE_W'(1)) begin
            pcnt_d = pulse_count_per_group_q;
            gcnt_d = gcnt_q - PULSE_W'(1);
          end else begin
            state_d = LSBS_DONE;
          end
        end
      end
      LSBS_DONE: begin
        if (!OFF_CMD_I && !force_br) begin
          state_d = LSBS_IDLE;
        end
      end
      default: state_d = LSBS_IDLE;
    endcase
    if (force_br && state_q == LSBS_DONE) begin
      state_d = LSBS_DONE;
    end
    if (!OFF_CMD_I && !force_br && state_q != LSBS_IDLE) begin
      state_d = LSBS_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      LOWSIDE_ON_O    <= 1'b0;
      BRIDGE_REL_O    <= 1'b1;
      BRAKING_O       <= 1'b0;
      PUMPUP_LIM_EN_O <= 1'b1;
    end else begin
      LOWSIDE_ON_O    <= (state_d == LSBS_ON);
      BRIDGE_REL_O    <= (state_d != LSBS_ON);
      BRAKING_O       <= (state_d != LSBS_IDLE);
      PUMPUP_LIM_EN_O <= !((state_d == LSBS_ON) || (state_d == LSBS_OFF));
    end
  end
endmodule

//--- dv/lsbs_asserts.sv
// Port rules of the brake sequencer, bound to the top.
// Assumes APB writes land at the access edge and the reset values of the map.
`timescale 1ns/1ps
`include "lsbs_params.svh"
module lsbs_asserts (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PSLVERR_O,
  input wire logic        OFF_CMD_I,
  input wire logic [15:0] EFREQ_I,
  input wire logic        LOWSIDE_ON_O,
  input wire logic        BRIDGE_REL_O,
  input wire logic        BRAKING_O,
  input wire logic        PUMPUP_LIM_EN_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic [1:0]  ctrl_q;
  logic [15:0] guard_q;
  logic        first_q;
  wire         acc = PSEL_I && PENABLE_I;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ctrl_q  <= 2'h1;
      guard_q <= `LSBS_RST_GUARD;
      first_q <= 1'b1;
    end else begin
      if (acc && PWRITE_I && PADDR_I == `LSBS_OFF_CTRL) ctrl_q <= PWDATA_I[1:0];
      if (acc && PWRITE_I && PADDR_I == `LSBS_OFF_GUARD) guard_q <= PWDATA_I[15:0];
      // Cleared by the first closure, so only the speed gate is judged
      first_q <= !BRAKING_O || (first_q && !LOWSIDE_ON_O);
    end
  end
  AST_REL_INV:
    assert property (BRIDGE_REL_O == !LOWSIDE_ON_O) else $error("release not inverse of low side");
  AST_PUMP_OFF:
    assert property (LOWSIDE_ON_O |-> !PUMPUP_LIM_EN_O) else $error("pump-up limit on while closed");
  AST_IDLE_PUMP:
    assert property (!BRAKING_O |-> PUMPUP_LIM_EN_O) else $error("pump-up limit off while idle");
  AST_UNMAPPED:
    assert property (acc && PADDR_I >= 12'h020 |-> PSLVERR_O) else $error("unmapped access not flagged");
  AST_START:
    assert property ($rose(OFF_CMD_I) && ctrl_q[0] |-> ##[1:3] BRAKING_O) else $error("brake not started");
  AST_NO_BRAKE:
    assert property (ctrl_q == 2'h0 && !BRAKING_O |=> !BRAKING_O) else $error("brake while disabled");
  AST_ABORT:
    assert property ($fell(OFF_CMD_I) && !ctrl_q[1] |-> ##[1:3] !BRAKING_O) else $error("brake not left");
  AST_FORCE:
    assert property (ctrl_q[1] && BRAKING_O |=> BRAKING_O) else $error("forced brake left");
  AST_COAST:
    assert property (first_q && BRAKING_O && !LOWSIDE_ON_O && $past(EFREQ_I) >= guard_q && EFREQ_I >= guard_q
      |=> !LOWSIDE_ON_O) else $error("closed while too fast");
  cover property ($rose(LOWSIDE_ON_O));
  cover property (first_q && BRAKING_O && EFREQ_I >= guard_q);
  cover property ($fell(BRAKING_O));
endmodule
bind lsbs_top lsbs_asserts u_chk (.CLK_SYS_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
  .PSLVERR_O, .OFF_CMD_I, .EFREQ_I, .LOWSIDE_ON_O, .BRIDGE_REL_O, .BRAKING_O, .PUMPUP_LIM_EN_O);

//--- dv/lsbs_fets.sv
// Model of the bridge's low-side switches.
// Assumes the gate command is synchronous to the system clock.
`timescale 1ns/1ps
module lsbs_fets (
  input  wire logic        clk_i,    // System clock
  input  wire logic        gate_i,   // Close all low sides
  input  wire logic        clr_i,    // Clear counters
  output logic      [15:0] pulses_o, // Closures seen
  output logic      [15:0] on_cyc_o  // Cycles closed
);
  logic gate_q;
  always_ff @(posedge clk_i) begin
    gate_q   <= gate_i;
    pulses_o <= clr_i ? 16'h0 : pulses_o + 16'(gate_i && !gate_q);
    on_cyc_o <= clr_i ? 16'h0 : on_cyc_o + 16'(gate_i);
  end
endmodule

//--- dv/test_low_side_brake_sequencer.sv
// Bench of the brake sequencer: APB tasks and braking scenarios.
// Assumes the design, the switch model and the checker are compiled first.
`timescale 1ns/1ps
module test_low_side_brake_sequencer;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, cmd = 0, clr = 1, re;
  logic [11:0] addr = 0;
  logic [31:0] wdat = 0, rdat, rd;
  logic        ready, err, lon, rel, brk, pump;
  logic [15:0] efreq = 0, pulses, oncyc;
  logic [31:0] rv [8] = '{32'h1, 32'h4, 32'h2, 32'h19, 32'h19, 32'h100, 32'h10, 32'h0};
  int          errors = 0, total_checks = 0;
  always #20 clk = ~clk;
  lsbs_top uut (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr),
    .PWDATA_I(wdat), .PRDATA_O(rdat), .PREADY_O(ready), .PSLVERR_O(err), .OFF_CMD_I(cmd), .EFREQ_I(efreq),
    .LOWSIDE_ON_O(lon), .BRIDGE_REL_O(rel), .BRAKING_O(brk), .PUMPUP_LIM_EN_O(pump));
  lsbs_fets fets (.clk_i(clk), .gate_i(lon), .clr_i(clr), .pulses_o(pulses), .on_cyc_o(oncyc));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (ready !== 1'b1);
    // Taken at the edge that completes the transfer
    rd = rdat;
    re = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic cfg(input logic [31:0] p, g, on, off);
    apb(1, 12'h004, p);
    apb(1, 12'h008, g);
    apb(1, 12'h00c, on);
    apb(1, 12'h010, off);
  endtask
  task automatic arm;
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    cmd <= 1;
  endtask
  task automatic wait_state(input logic [2:0] s);
    rd = 'x;
    for (int n = 0; n < 1500 && rd[2:0] !== s; n++) apb(0, 12'h01c, 0);
    chk("state", 32'(s), 32'(rd[2:0]));
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    clr <= 0;
    for (int i = 0; i < 8; i++) begin
      apb(0, 12'(4 * i), 0);
      chk("reset value", rv[i], rd);
    end
    apb(0, 12'h020, 0);
    chk("unmapped read", 0, rd);
    chk("unmapped error", 1, 32'(re));
    $display("test registers done");
    apb(1, 12'h000, 0);
    arm;
    repeat (100) @(posedge clk);
    chk("disabled brake", 0, 32'({brk, lon}));
    cmd <= 0;
    apb(1, 12'h000, 1);
    cfg(3, 2, 2, 3);
    arm;
    wait_state(3'h5);
    chk("pulse total", 6, 32'(pulses));
    chk("on time range", 1, 32'(oncyc > 16'd275 && oncyc <= 16'd300));
    cmd <= 0;
    repeat (4) @(posedge clk);
    chk("idle after drop", 0, 32'(brk));
    $display("test pulsed done");
    efreq <= 16'h0100;
    apb(1, 12'h018, 2);
    arm;
    repeat (300) @(posedge clk);
    chk("coast closures", 0, 32'(pulses));
    chk("coast release", 3, 32'({brk, rel}));
    efreq <= 16'h00ff;
    wait_state(3'h5);
    chk("pulses after coast", 6, 32'(pulses));
    cmd <= 0;
    efreq <= 0;
    $display("test overspeed done");
    cfg(3, 2, 32'hffff, 0);
    arm;
    repeat (1000) @(posedge clk);
    chk("continuous on", 2, 32'({lon, pump}));
    chk("single closure", 1, 32'(pulses));
    cmd <= 0;
    repeat (4) @(posedge clk);
    chk("continuous released", 0, 32'(lon));
    $display("test continuous done");
    cfg(3, 2, 2, 3);
    apb(1, 12'h000, 3);
    wait_state(3'h5);
    repeat (100) @(posedge clk);
    chk("forced brake held", 1, 32'(brk));
    apb(1, 12'h000, 1);
    repeat (4) @(posedge clk);
    chk("force released", 0, 32'(brk));
    $display("test force done");
    stop_test;
  end
endmodule
